// ==== logic/eil_pkg.sv ====
// Package for the external interrupt latch block.
// Assumes a single 10 MHz bus clock and classic Wishbone register access.
package eil_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0] EIL_ADDR_STATUS_CONTROL = 4'h0;
    localparam int EIL_ADDR_W = 4;
    localparam int EIL_DATA_W = 32;

    // ----------------------------------------
    // Field positions of ext_int_status_control
    // ----------------------------------------
    localparam int EIL_BIT_LEVEL_SELECT = 0;
    localparam int EIL_BIT_MASK = 1;
    localparam int EIL_BIT_ACK = 2;
    localparam int EIL_BIT_EVENT_FLAG = 3;
    localparam int EIL_BIT_PIN_LEVEL = 4;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic EIL_RST_LEVEL_SELECT = 1'h0;
    localparam logic EIL_RST_MASK = 1'h0;
    localparam logic EIL_RST_LATCH = 1'h0;
    localparam logic [31:0] EIL_UNMAPPED_READ = 32'h0000_0000;

    // Wishbone request carried as one bundle
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [EIL_ADDR_W-1:0] adr;
        logic [EIL_DATA_W-1:0] dat;
    } eil_wb_req_t;

    // Wishbone answer
    typedef struct packed {
        logic ack;
        logic [EIL_DATA_W-1:0] dat;
    } eil_wb_rsp_t;

endpackage : eil_pkg

// ==== logic/eil_pin_sync.sv ====
// Two-stage synchroniser with falling-edge detect for the interrupt pin.
// Assumes the pin is asynchronous to mclk; the first stage feeds only the second.
`timescale 1ns/1ps
module eil_pin_sync
    import eil_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic pin_n,
    output logic level,
    output logic fall
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } eil_sync_state_t;

    eil_sync_state_t st_reg;
    eil_sync_state_t st_next;

    // ----------------------------------------
    // Synchroniser and edge detect
    // ----------------------------------------
    // Pin idles high, so reset to high avoids a fake edge
    always_comb begin
        st_next = st_reg;
        st_next.meta = pin_n; // RULE16
        st_next.sync = st_reg.meta; // RULE16
        st_next.prev = st_reg.sync;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.sync;
    assign fall = st_reg.prev & ~st_reg.sync; // RULE1

endmodule : eil_pin_sync

// ==== logic/eil_wb_slave.sv ====
// Classic Wishbone slave front end: one-cycle-late ack, single register.
// Assumes the master holds the request until it samples ack high.
`timescale 1ns/1ps
module eil_wb_slave
    import eil_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input eil_wb_req_t req,
    input wire logic [7:0] rd_value,
    output eil_wb_rsp_t rsp,
    output logic wr_pulse,
    output logic [7:0] wr_data
);

    typedef struct packed {
        logic ack;
        logic [EIL_DATA_W-1:0] dat;
    } eil_wbs_state_t;

    eil_wbs_state_t st_reg;
    eil_wbs_state_t st_next;
    logic take;
    logic hit;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // Ack drops after one cycle so a held request is not taken twice
    assign take = req.cyc & req.stb & ~st_reg.ack;
    assign hit = (req.adr == EIL_ADDR_STATUS_CONTROL);

    always_comb begin
        st_next = st_reg;
        st_next.ack = take;
        if (take & ~req.we) begin
            st_next.dat = hit ? {24'h00_0000, rd_value} : EIL_UNMAPPED_READ;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Write lands on the edge where ack is sampled high
    assign wr_pulse = st_reg.ack & req.cyc & req.stb & req.we & hit & req.sel[0];
    assign wr_data = req.dat[7:0];
    assign rsp.ack = st_reg.ack;
    assign rsp.dat = st_reg.dat;

endmodule : eil_wb_slave

// ==== logic/eil_top.sv ====
// External interrupt latch: one active-low pin, request latch, mask, flag.
// Assumes the CPU drives a one-cycle vector fetch strobe and reads vectors itself.
`timescale 1ns/1ps

// Functional notes
// (RULE1) A falling edge on the pin sets the request latch in either mode.
// (RULE2) A fetch of the external vector clears the latch that caused it.
// (RULE3) Writing 1 to the acknowledge bit clears the latch like a vector fetch.
// (RULE4) Reset clears the request latch.
// (RULE5) The level select bit picks edge-plus-level when 1, edge only when 0, reset 0.
// (RULE6) In edge-plus-level mode the latch clears only after a clear event and a high pin.
// (RULE7) In edge-only mode a fetch or acknowledge clears the latch at once.
// (RULE8) The mask bit withholds the request from the CPU but keeps the latch, reset 0.
// (RULE9) The acknowledge bit is write-only, reads 0 and resets to 0.
// (RULE10) A falling edge after an acknowledge latches a new request.
// (RULE11) An unmasked taken request leads to the vector at the two fixed addresses.
// (RULE12) A read-only flag shows 1 when an external event has occurred.
// (RULE13) The CPU also suppresses the request while its global mask is set.
// (RULE14) The pin level is offered to the CPU for its branch-on-pin instructions.
// (RULE15) Software should mask requests inside a level-triggered service routine.
// (RULE16) The pin passes two flip-flops before edge and level use.
// (RULE17) Register fields sit in a chosen layout with unused bits reading 0.
module eil_top
    import eil_pkg::*;
#(
    parameter logic [15:0] VECTOR_ADDR_HI = 16'hfffa,
    parameter logic [15:0] VECTOR_ADDR_LO = 16'hfffb
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic irq_pin_n,
    input wire logic vector_fetch,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [EIL_ADDR_W-1:0] wb_adr_i,
    input wire logic [EIL_DATA_W-1:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [EIL_DATA_W-1:0] wb_dat_o,
    output logic cpu_irq_request,
    output logic [15:0] vector_addr_hi,
    output logic [15:0] vector_addr_lo,
    output logic pin_level
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic level_sensitive_select;
        logic request_mask;
        logic request_latch;
        logic clear_pending;
        logic pin_level;
    } eil_state_t;

    eil_state_t st_reg;
    eil_state_t st_next;

    eil_wb_req_t bus_req;
    eil_wb_rsp_t bus_rsp;
    logic wr_pulse;
    logic [7:0] wr_data;
    logic [7:0] rd_value;
    logic pin_sync;
    logic pin_fall;
    logic sw_ack;
    logic clear_event;

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    eil_pin_sync u_sync (
        .mclk(mclk),
        .rst(rst),
        .pin_n(irq_pin_n),
        .level(pin_sync),
        .fall(pin_fall)
    );

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    assign bus_req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                       adr: wb_adr_i, dat: wb_dat_i};

    eil_wb_slave u_wb (
        .mclk(mclk),
        .rst(rst),
        .req(bus_req),
        .rd_value(rd_value),
        .rsp(bus_rsp),
        .wr_pulse(wr_pulse),
        .wr_data(wr_data)
    );

    // Read image; acknowledge bit and spare bits always 0
    always_comb begin
        rd_value = 8'h00; // RULE17
        rd_value[EIL_BIT_LEVEL_SELECT] = st_reg.level_sensitive_select;
        rd_value[EIL_BIT_MASK] = st_reg.request_mask;
        rd_value[EIL_BIT_ACK] = 1'b0; // RULE9
        rd_value[EIL_BIT_EVENT_FLAG] = st_reg.request_latch; // RULE12
        rd_value[EIL_BIT_PIN_LEVEL] = st_reg.pin_level; // RULE14
    end

    // Acknowledge is a pulse only, never stored
    assign sw_ack = wr_pulse & wr_data[EIL_BIT_ACK]; // RULE3 RULE9
    assign clear_event = sw_ack | vector_fetch; // RULE2

    // ----------------------------------------
    // Latch and control
    // ----------------------------------------
    // A new edge beats a clear in the same cycle so no event is lost
    always_comb begin
        st_next = st_reg;
        st_next.pin_level = pin_sync;
        if (wr_pulse) begin
            st_next.level_sensitive_select = wr_data[EIL_BIT_LEVEL_SELECT]; // RULE5
            st_next.request_mask = wr_data[EIL_BIT_MASK]; // RULE8
        end
        if (st_reg.level_sensitive_select) begin
            // Clear waits for both the event and a high pin, either order
            if (clear_event & st_reg.request_latch) begin
                st_next.clear_pending = 1'b1; // RULE6
            end
            if ((clear_event | st_reg.clear_pending) & pin_sync) begin
                st_next.request_latch = 1'b0; // RULE6
                st_next.clear_pending = 1'b0;
            end
        end else begin
            st_next.clear_pending = 1'b0;
            if (clear_event) begin
                st_next.request_latch = 1'b0; // RULE7
            end
        end
        if (pin_fall) begin
            st_next.request_latch = 1'b1; // RULE1 RULE10
            st_next.clear_pending = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg.level_sensitive_select <= EIL_RST_LEVEL_SELECT; // RULE5
            st_reg.request_mask <= EIL_RST_MASK; // RULE8
            st_reg.request_latch <= EIL_RST_LATCH; // RULE4
            st_reg.clear_pending <= 1'b0;
            st_reg.pin_level <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Mask gates the request only; latch is untouched. CPU global mask is its own job.
    assign cpu_irq_request = st_reg.request_latch & ~st_reg.request_mask; // RULE8 RULE13
    assign vector_addr_hi = VECTOR_ADDR_HI; // RULE11
    assign vector_addr_lo = VECTOR_ADDR_LO; // RULE11
    assign pin_level = st_reg.pin_level; // RULE14
    assign wb_ack_o = bus_rsp.ack;
    assign wb_dat_o = bus_rsp.dat;

endmodule : eil_top

// ==== dv/eil_irq_src.sv ====
// Model of the external source on the interrupt pin.
// Open-drain with pull-up: a released pin reads high.
`timescale 1ns/1ps
module eil_irq_src (
    input wire logic pull_low,
    output logic irq_pin_n
);
    // Pull-up wins whenever the source lets go
    assign irq_pin_n = pull_low ? 1'b0 : 1'b1;
endmodule : eil_irq_src

// ==== dv/eil_top_asserts.sv ====
// Concurrent checks on the ports of eil_top.
// Bound into eil_top; one clock, sync reset.
`timescale 1ns/1ps
module eil_chk
    import eil_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic irq_pin_n,
    input wire logic vector_fetch,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [EIL_DATA_W-1:0] wb_dat_o,
    input wire logic cpu_irq_request,
    input wire logic [15:0] vector_addr_hi,
    input wire logic [15:0] vector_addr_lo,
    input wire logic pin_level
);
    default clocking cb @(posedge mclk); endclocking
    // Bus answer: one cycle late, one cycle long
    ack_timely_a: assert property (disable iff (rst) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (disable iff (rst) wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    read_pad_a: assert property (disable iff (rst) wb_ack_o |-> wb_dat_o[31:5] == 27'h0)
        else $error("unused bits set");
    ack_bit_a: assert property (disable iff (rst) wb_ack_o |-> !wb_dat_o[2])
        else $error("ack bit read 1");
    vector_addr_a: assert property (disable iff (rst)
        vector_addr_hi == 16'hfffa && vector_addr_lo == 16'hfffb)
        else $error("vector address");
    pin_follow_a: assert property (disable iff (rst) $stable(irq_pin_n)[*4] |-> pin_level == irq_pin_n)
        else $error("pin level stale");
    // Pin long high: no edge in flight, so a fetch must clear
    fetch_clear_a: assert property (disable iff (rst) irq_pin_n[*5] ##0 vector_fetch |=> !cpu_irq_request)
        else $error("fetch kept request");
    // Pin low, no bus cycle, no fetch: nothing may drop it
    irq_hold_a: assert property (disable iff (rst)
        !irq_pin_n[*4] ##0 (cpu_irq_request && !wb_cyc_i && !vector_fetch) |=> cpu_irq_request)
        else $error("request dropped");
    reset_clear_a: assert property (disable iff (1'b0) rst |=> !cpu_irq_request && !wb_ack_o && pin_level)
        else $error("reset state");
endmodule : eil_chk

bind eil_top eil_chk eil_chk_inst (.mclk(mclk), .rst(rst), .irq_pin_n(irq_pin_n),
    .vector_fetch(vector_fetch), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .cpu_irq_request(cpu_irq_request), .vector_addr_hi(vector_addr_hi),
    .vector_addr_lo(vector_addr_lo), .pin_level(pin_level));

// ==== dv/eil_top_bench.sv ====
// Self-checking bench for eil_top.
// Pin driven through the source model, registers over Wishbone.
`timescale 1ns/1ps
module eil_top_bench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic low = 1'b0;
    logic fetch = 1'b0;
    logic cyc = 1'b0;
    logic wen = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] q;
    logic [31:0] rdat;
    logic [15:0] vhi;
    logic [15:0] vlo;
    logic pin_n;
    logic ack;
    logic irq;
    logic lvl;
    int fail_count = 0;
    int check_count = 0;

    always #50 mclk = ~mclk;

    eil_irq_src eil_irq_src_inst (.pull_low(low), .irq_pin_n(pin_n));
    eil_top eil_top_inst (.mclk(mclk), .rst(rst), .irq_pin_n(pin_n), .vector_fetch(fetch),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(wen), .wb_sel_i(4'hf), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat), .cpu_irq_request(irq),
        .vector_addr_hi(vhi), .vector_addr_lo(vlo), .pin_level(lvl));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Classic cycle: hold until ack, then idle one cycle
    task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        wen <= we;
        adr <= a;
        wdat <= {24'h0, d};
        do @(posedge mclk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        wen <= 1'b0;
        @(posedge mclk);
    endtask : bus

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, {24'h0, e});
    endtask : rd

    // Settle time covers sync, edge register and latch
    task automatic pin(input logic on);
        low <= on;
        repeat (6) @(posedge mclk);
    endtask : pin

    task automatic pulse;
        // CPU takes the vector only while a request is offered; its global mask stays clear
        fetch <= irq;
        @(posedge mclk);
        fetch <= 1'b0;
        @(posedge mclk);
    endtask : pulse

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    // Tests take about a hundred cycles
    initial begin
        repeat (2000) @(posedge mclk);
        fail_count++;
        close_out();
    end

    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(4'h0, 8'h10);
        rd(4'h1, 8'h00);
        chk({vhi, vlo}, 32'hfffafffb);
        $display("reset test done");
        pin(1'b1);
        chk(irq, 1);
        chk(lvl, 0);
        rd(4'h0, 8'h08);
        pulse();
        chk(irq, 0);
        pin(1'b0);
        $display("edge test done");
        bus(1'b1, 4'h0, 8'h02);
        pin(1'b1);
        chk(irq, 0);
        rd(4'h0, 8'h0a);
        bus(1'b1, 4'h0, 8'h00);
        chk(irq, 1);
        bus(1'b1, 4'h0, 8'h04);
        chk(irq, 0);
        pin(1'b0);
        pin(1'b1);
        chk(irq, 1);
        $display("mask test done");
        // Mode goes in on its own: an acknowledge in the same write still sees edge mode
        bus(1'b1, 4'h0, 8'h01);
        // Service routine masks and acknowledges a level request in one write
        bus(1'b1, 4'h0, 8'h07);
        rd(4'h0, 8'h0b);
        bus(1'b1, 4'h0, 8'h01);
        chk(irq, 1);
        pin(1'b0);
        chk(irq, 0);
        pin(1'b1);
        pin(1'b0);
        chk(irq, 1);
        pulse();
        chk(irq, 0);
        pin(1'b1);
        pin(1'b0);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk(irq, 0);
        rd(4'h0, 8'h10);
        $display("level test done");
        close_out();
    end
endmodule : eil_top_bench
